// ==== include/pfs_pkg.sv ====
`default_nettype none
package pfs_pkg;
   localparam int PORTS = 4;

   // function codes written by the host, one per port
   localparam logic [3:0] FN_DISABLE = 4'h0;
   localparam logic [3:0] FN_DISC_LOW = 4'h1;
   localparam logic [3:0] FN_DISC_HIGH = 4'h2;
   localparam logic [3:0] FN_V_SAMPLE = 4'h3;
   localparam logic [3:0] FN_LEGACY = 4'h4;
   localparam logic [3:0] FN_CLASSIFY = 4'h5;
   localparam logic [3:0] FN_RAMP_UP = 4'h6;
   localparam logic [3:0] FN_C_SAMPLE = 4'h7;
   localparam logic [3:0] FN_RAMP_DOWN = 4'h8;
   localparam logic [3:0] FN_LOW_SIDE_AC_PROBE = 4'h9;
   localparam logic [3:0] FN_HIGH_SIDE_AC_PROBE = 4'ha;
   localparam logic [3:0] FN_SINGLE_CURRENT_SAMPLE = 4'hb;
   localparam logic [3:0] FN_DIE_TEMPERATURE_SAMPLE = 4'hc;
   localparam logic [3:0] FN_LAST = 4'hc;

   // result register select
   localparam logic [1:0] RES_DET = 2'h0;
   localparam logic [1:0] RES_CUR = 2'h1;
   localparam logic [1:0] RES_VOLT = 2'h2;
   localparam logic [1:0] RES_TEMP = 2'h3;
   localparam int RES_DONE_BIT = 15;
   localparam logic [15:0] RES_RST = 16'h0000;

   // continuous sample: slots 0..30 current, slot 31 voltage
   localparam logic [4:0] CS_VOLT_SLOT = 5'h1f;

   // timing, 40 MHz clock
   localparam int CLK_HZ = 40_000_000;
   localparam int SETTLE_MS = 5;
   localparam int CONV_MS = 18;
   localparam int RAMP_UP_US = 500;
   localparam int RAMP_DOWN_US = 300;
   localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
   localparam int CONV_CYC = CONV_MS * (CLK_HZ / 1000);
   localparam int RAMP_UP_CYC = RAMP_UP_US * (CLK_HZ / 1_000_000);
   localparam int RAMP_DOWN_CYC = RAMP_DOWN_US * (CLK_HZ / 1_000_000);

   typedef logic [19:0] pfs_cnt_t;

   typedef enum logic [2:0] {
      PFS_IDLE = 3'b000,
      PFS_SETTLE = 3'b001,
      PFS_PRE = 3'b010,
      PFS_CHARGE = 3'b011,
      PFS_COARSE = 3'b100,
      PFS_FINE = 3'b101,
      PFS_RAMP = 3'b110,
      PFS_HOLD = 3'b111
   } pfs_phase_t;
endpackage
`default_nettype wire

// ==== include/pfs_link_if.sv ====
`default_nettype none
interface pfs_link_if;
   logic fn_valid;
   logic fn_ready;
   logic [1:0] fn_port;
   logic [3:0] fn_code;
   logic [3:0] fn_done;
   logic rd_req;
   logic [1:0] rd_port;
   logic [1:0] rd_sel;
   logic rd_valid;
   logic [15:0] rd_data;

   modport device (
      input fn_valid, fn_port, fn_code, rd_req, rd_port, rd_sel,
      output fn_ready, fn_done, rd_valid, rd_data
   );
   modport host (
      output fn_valid, fn_port, fn_code, rd_req, rd_port, rd_sel,
      input fn_ready, fn_done, rd_valid, rd_data
   );
endinterface
`default_nettype wire

// ==== verilog/pfs_device_end.sv ====
// Operation
// - thirteen functions, host writes then polls done
// - disable turns port off, functions idle
// - low detection probe, current to detection register
// - high detection probe, current to detection register
// - detection settles, converts, then sets done
// - probe level held; detection result held
// - voltage sample stored in voltage register
// - legacy test source, averaged voltage stored
// - classify level, current stored, then done
// - class level and current result held
// - host keeps one port classifying at once
// - ramp-up turns switch on, controlled current
// - continuous 31 current, 1 voltage, repeating
// - ramp-down turns switch off until zero
// - low-side probe transistor, voltage stored
// - high-side probe transistor, voltage stored
// - single current sample stored in current register
// - die temperature stored in temperature register
// - result top bit flags conversion complete
// - host waits for conversion before next function, except disable
// - conversion: precharge, charge, coarse, fine discharge
// - disable clears latched fault and fault status
// - code 0111b continuous; undercurrent only there
`default_nettype none
module pfs_device_end #(
   parameter int P_SETTLE_CYC = pfs_pkg::SETTLE_CYC,
   parameter int P_CONV_CYC = pfs_pkg::CONV_CYC,
   parameter int P_RAMP_UP_CYC = pfs_pkg::RAMP_UP_CYC,
   parameter int P_RAMP_DOWN_CYC = pfs_pkg::RAMP_DOWN_CYC
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // host link
   pfs_link_if.device link,
   // converter and comparators
   input wire logic [3:0][14:0] i_adc_value,
   input wire logic [3:0] i_under_current,
   // port conditions
   output logic [3:0] o_probe_low,
   output logic [3:0] o_probe_high,
   output logic [3:0] o_class_level,
   output logic [3:0] o_legacy_source,
   output logic [3:0] o_low_side_fet,
   output logic [3:0] o_high_side_fet,
   output logic [3:0] o_switch_on,
   output logic [3:0] o_ramp_up,
   output logic [3:0] o_ramp_down,
   // converter control
   output logic [3:0] o_adc_busy,
   output logic [3:0][1:0] o_adc_phase,
   output logic [3:0][1:0] o_adc_source,
   // fault
   output logic [3:0] o_fault
);
   // each phase takes a quarter of the conversion; a real integrator
   // would end fine discharge on its comparator instead
   localparam pfs_pkg::pfs_cnt_t PH_LAST = pfs_pkg::pfs_cnt_t'(P_CONV_CYC / 4 - 1);
   localparam pfs_pkg::pfs_cnt_t SETTLE_LAST = pfs_pkg::pfs_cnt_t'(P_SETTLE_CYC - 1);
   localparam pfs_pkg::pfs_cnt_t UP_LAST = pfs_pkg::pfs_cnt_t'(P_RAMP_UP_CYC - 1);
   localparam pfs_pkg::pfs_cnt_t DOWN_LAST = pfs_pkg::pfs_cnt_t'(P_RAMP_DOWN_CYC - 1);

   logic [3:0] fn_r [4];
   logic [3:0] fn_nxt [4];
   pfs_pkg::pfs_phase_t phase_r [4];
   pfs_pkg::pfs_phase_t phase_nxt [4];
   pfs_pkg::pfs_cnt_t cnt_r [4];
   pfs_pkg::pfs_cnt_t cnt_nxt [4];
   logic [4:0] seq_r [4];
   logic [4:0] seq_nxt [4];
   logic [3:0] done_r;
   logic [3:0] done_nxt;
   logic [3:0] sw_r;
   logic [3:0] sw_nxt;
   logic [3:0] fault_r;
   logic [3:0] fault_nxt;
   logic [15:0] res_r [4][4];
   logic [15:0] res_nxt [4][4];
   logic rd_valid_r;
   logic rd_valid_nxt;
   logic [15:0] rd_data_r;
   logic [15:0] rd_data_nxt;

   // which result register a conversion of this function lands in
   function automatic logic [1:0] fn_target(input logic [3:0] code, input logic [4:0] seq);
      logic [1:0] t;
      t = pfs_pkg::RES_VOLT;
      case (code)
         pfs_pkg::FN_DISC_LOW, pfs_pkg::FN_DISC_HIGH: t = pfs_pkg::RES_DET;
         pfs_pkg::FN_CLASSIFY, pfs_pkg::FN_SINGLE_CURRENT_SAMPLE: t = pfs_pkg::RES_CUR;
         pfs_pkg::FN_DIE_TEMPERATURE_SAMPLE: t = pfs_pkg::RES_TEMP;
         pfs_pkg::FN_C_SAMPLE: begin
            t = (seq == pfs_pkg::CS_VOLT_SLOT) ? pfs_pkg::RES_VOLT : pfs_pkg::RES_CUR;
         end
         default: t = pfs_pkg::RES_VOLT;
      endcase
      return t;
   endfunction

   function automatic logic is_conv(input pfs_pkg::pfs_phase_t ph);
      return (ph == pfs_pkg::PFS_PRE) || (ph == pfs_pkg::PFS_CHARGE) ||
             (ph == pfs_pkg::PFS_COARSE) || (ph == pfs_pkg::PFS_FINE);
   endfunction

   always_comb begin
      logic [1:0] tgt;
      tgt = pfs_pkg::RES_DET;
      fn_nxt = fn_r;
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      seq_nxt = seq_r;
      done_nxt = done_r;
      sw_nxt = sw_r;
      fault_nxt = fault_r;
      res_nxt = res_r;
      for (int p = 0; p < pfs_pkg::PORTS; p++) begin
         tgt = fn_target(fn_r[p], seq_r[p]);
         case (phase_r[p])
            pfs_pkg::PFS_SETTLE: begin
               if (cnt_r[p] == '0) begin
                  phase_nxt[p] = pfs_pkg::PFS_PRE;
                  cnt_nxt[p] = PH_LAST;
               end else begin
                  cnt_nxt[p] = cnt_r[p] - 1'b1;
               end
            end
            pfs_pkg::PFS_PRE, pfs_pkg::PFS_CHARGE, pfs_pkg::PFS_COARSE: begin
               if (cnt_r[p] == '0) begin
                  // phases advance strictly in order
                  phase_nxt[p] = pfs_pkg::pfs_phase_t'(phase_r[p] + 3'h1);
                  cnt_nxt[p] = PH_LAST;
               end else begin
                  cnt_nxt[p] = cnt_r[p] - 1'b1;
               end
            end
            pfs_pkg::PFS_FINE: begin
               if (cnt_r[p] == '0) begin
                  res_nxt[p][tgt] = {1'b1, i_adc_value[p]};
                  done_nxt[p] = 1'b1;
                  if (fn_r[p] == pfs_pkg::FN_C_SAMPLE) begin
                     if (tgt == pfs_pkg::RES_CUR && i_under_current[p]) begin
                        fault_nxt[p] = 1'b1;
                        sw_nxt[p] = 1'b0;
                        fn_nxt[p] = pfs_pkg::FN_DISABLE;
                        phase_nxt[p] = pfs_pkg::PFS_IDLE;
                     end else begin
                        seq_nxt[p] = seq_r[p] + 5'h01;
                        res_nxt[p][fn_target(fn_r[p], seq_r[p] + 5'h01)][pfs_pkg::RES_DONE_BIT] = 1'b0;
                        phase_nxt[p] = pfs_pkg::PFS_PRE;
                        cnt_nxt[p] = PH_LAST;
                     end
                  end else begin
                     // probe levels stay applied in hold
                     phase_nxt[p] = pfs_pkg::PFS_HOLD;
                  end
               end else begin
                  cnt_nxt[p] = cnt_r[p] - 1'b1;
               end
            end
            pfs_pkg::PFS_RAMP: begin
               if (cnt_r[p] == '0) begin
                  phase_nxt[p] = pfs_pkg::PFS_HOLD;
                  done_nxt[p] = 1'b1;
                  if (fn_r[p] == pfs_pkg::FN_RAMP_DOWN) begin
                     sw_nxt[p] = 1'b0;
                  end
               end else begin
                  cnt_nxt[p] = cnt_r[p] - 1'b1;
               end
            end
            default: begin
            end
         endcase
         // a new function overrides whatever the port was doing; codes
         // above the last one are ignored
         if (link.fn_valid && link.fn_port == 2'(p) && link.fn_code <= pfs_pkg::FN_LAST) begin
            fn_nxt[p] = link.fn_code;
            done_nxt[p] = 1'b0;
            seq_nxt[p] = 5'h00;
            tgt = fn_target(link.fn_code, 5'h00);
            case (link.fn_code)
               pfs_pkg::FN_DISABLE: begin
                  phase_nxt[p] = pfs_pkg::PFS_IDLE;
                  sw_nxt[p] = 1'b0;
                  fault_nxt[p] = 1'b0;
                  done_nxt[p] = 1'b1;
               end
               pfs_pkg::FN_DISC_LOW, pfs_pkg::FN_DISC_HIGH, pfs_pkg::FN_CLASSIFY: begin
                  phase_nxt[p] = pfs_pkg::PFS_SETTLE;
                  cnt_nxt[p] = SETTLE_LAST;
                  res_nxt[p][tgt][pfs_pkg::RES_DONE_BIT] = 1'b0;
               end
               pfs_pkg::FN_RAMP_UP: begin
                  // a latched fault blocks repowering until disable
                  if (fault_r[p]) begin
                     phase_nxt[p] = pfs_pkg::PFS_HOLD;
                     done_nxt[p] = 1'b1;
                  end else begin
                     sw_nxt[p] = 1'b1;
                     phase_nxt[p] = pfs_pkg::PFS_RAMP;
                     cnt_nxt[p] = UP_LAST;
                  end
               end
               pfs_pkg::FN_RAMP_DOWN: begin
                  phase_nxt[p] = pfs_pkg::PFS_RAMP;
                  cnt_nxt[p] = DOWN_LAST;
               end
               default: begin
                  // sample functions go straight to precharge
                  phase_nxt[p] = pfs_pkg::PFS_PRE;
                  cnt_nxt[p] = PH_LAST;
                  res_nxt[p][tgt][pfs_pkg::RES_DONE_BIT] = 1'b0;
               end
            endcase
         end
      end
   end

   always_comb begin
      rd_valid_nxt = link.rd_req;
      rd_data_nxt = rd_data_r;
      if (link.rd_req) begin
         rd_data_nxt = res_r[link.rd_port][link.rd_sel];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int p = 0; p < pfs_pkg::PORTS; p++) begin
            fn_r[p] <= pfs_pkg::FN_DISABLE;
            phase_r[p] <= pfs_pkg::PFS_IDLE;
            cnt_r[p] <= '0;
            seq_r[p] <= 5'h00;
            for (int r = 0; r < 4; r++) begin
               res_r[p][r] <= pfs_pkg::RES_RST;
            end
         end
         done_r <= 4'h0;
         sw_r <= 4'h0;
         fault_r <= 4'h0;
         rd_valid_r <= 1'b0;
         rd_data_r <= pfs_pkg::RES_RST;
      end else begin
         fn_r <= fn_nxt;
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         seq_r <= seq_nxt;
         res_r <= res_nxt;
         done_r <= done_nxt;
         sw_r <= sw_nxt;
         fault_r <= fault_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   always_comb begin
      for (int p = 0; p < pfs_pkg::PORTS; p++) begin
         o_probe_low[p] = (fn_r[p] == pfs_pkg::FN_DISC_LOW);
         o_probe_high[p] = (fn_r[p] == pfs_pkg::FN_DISC_HIGH);
         o_class_level[p] = (fn_r[p] == pfs_pkg::FN_CLASSIFY);
         o_legacy_source[p] = (fn_r[p] == pfs_pkg::FN_LEGACY) && is_conv(phase_r[p]);
         o_low_side_fet[p] = (fn_r[p] == pfs_pkg::FN_LOW_SIDE_AC_PROBE);
         o_high_side_fet[p] = (fn_r[p] == pfs_pkg::FN_HIGH_SIDE_AC_PROBE);
         o_ramp_up[p] = (fn_r[p] == pfs_pkg::FN_RAMP_UP) && (phase_r[p] == pfs_pkg::PFS_RAMP);
         o_ramp_down[p] = (fn_r[p] == pfs_pkg::FN_RAMP_DOWN) &&
                          (phase_r[p] == pfs_pkg::PFS_RAMP);
         o_adc_busy[p] = is_conv(phase_r[p]);
         o_adc_phase[p] = is_conv(phase_r[p]) ? 2'(phase_r[p] - 3'h2) : 2'h0;
         o_adc_source[p] = fn_target(fn_r[p], seq_r[p]);
      end
   end

   assign o_switch_on = sw_r;
   assign o_fault = fault_r;
   assign link.fn_ready = 1'b1;
   assign link.fn_done = done_r;
   assign link.rd_valid = rd_valid_r;
   assign link.rd_data = rd_data_r;
endmodule
`default_nettype wire

// ==== verilog/pfs_host_end.sv ====
`default_nettype none
module pfs_host_end (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // device link
   pfs_link_if.host link,
   // function requests
   input wire logic i_cmd_valid,
   input wire logic [1:0] i_cmd_port,
   input wire logic [3:0] i_cmd_code,
   output logic o_cmd_ready,
   // result reads
   input wire logic i_rd_req,
   input wire logic [1:0] i_rd_port,
   input wire logic [1:0] i_rd_sel,
   output logic o_rd_valid,
   output logic o_rd_stale,
   output logic [15:0] o_rd_data,
   // port status
   output logic [3:0] o_port_busy
);
   logic [3:0] pend_r;
   logic [3:0] pend_nxt;
   logic [3:0] cls_r;
   logic [3:0] cls_nxt;
   logic rd_valid_r;
   logic rd_valid_nxt;
   logic rd_stale_r;
   logic rd_stale_nxt;
   logic [15:0] rd_data_r;
   logic [15:0] rd_data_nxt;
   logic allowed;
   logic issue;

   always_comb begin
      // disable is always let through so a port can be shut off at once
      allowed = !pend_r[i_cmd_port] || (i_cmd_code == pfs_pkg::FN_DISABLE);
      if (i_cmd_code == pfs_pkg::FN_CLASSIFY && (cls_r & ~(4'h1 << i_cmd_port)) != 4'h0) begin
         allowed = 1'b0;
      end
   end

   assign issue = i_cmd_valid && allowed && link.fn_ready;
   assign o_cmd_ready = allowed && link.fn_ready;
   assign link.fn_valid = i_cmd_valid && allowed;
   assign link.fn_port = i_cmd_port;
   assign link.fn_code = i_cmd_code;
   assign link.rd_req = i_rd_req;
   assign link.rd_port = i_rd_port;
   assign link.rd_sel = i_rd_sel;

   always_comb begin
      pend_nxt = pend_r & ~link.fn_done;
      cls_nxt = cls_r;
      if (issue) begin
         pend_nxt[i_cmd_port] = 1'b1;
         cls_nxt[i_cmd_port] = (i_cmd_code == pfs_pkg::FN_CLASSIFY);
      end
      rd_valid_nxt = 1'b0;
      rd_stale_nxt = 1'b0;
      rd_data_nxt = rd_data_r;
      if (link.rd_valid) begin
         rd_data_nxt = link.rd_data;
         rd_valid_nxt = link.rd_data[pfs_pkg::RES_DONE_BIT];
         rd_stale_nxt = !link.rd_data[pfs_pkg::RES_DONE_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pend_r <= 4'h0;
         cls_r <= 4'h0;
         rd_valid_r <= 1'b0;
         rd_stale_r <= 1'b0;
         rd_data_r <= pfs_pkg::RES_RST;
      end else begin
         pend_r <= pend_nxt;
         cls_r <= cls_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_stale_r <= rd_stale_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign o_rd_valid = rd_valid_r;
   assign o_rd_stale = rd_stale_r;
   assign o_rd_data = rd_data_r;
   assign o_port_busy = pend_r;
endmodule
`default_nettype wire

// ==== tb/pfs_link_asserts.sv ====
`default_nettype none
module pfs_link_asserts #(
   parameter int P_SETTLE_CYC = 20,
   parameter int P_CONV_CYC = 16,
   parameter int P_RAMP_UP_CYC = 10
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic fn_valid,
   input wire logic fn_ready,
   input wire logic [1:0] fn_port,
   input wire logic [3:0] fn_code,
   input wire logic [3:0] fn_done,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data
);
   // timing only on port 0, which the bench keeps free of faults
   localparam int SAMP_D = P_CONV_CYC - 1;
   localparam int DET_D = P_SETTLE_CYC + P_CONV_CYC - 1;
   localparam int RUP_D = P_RAMP_UP_CYC - 1;
   logic go0;
   assign go0 = fn_valid && fn_port == 2'h0;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   sequence s_samp_end;
      ##SAMP_D !fn_done[0] ##1 fn_done[0];
   endsequence
   sequence s_det_end;
      ##DET_D !fn_done[0] ##1 fn_done[0];
   endsequence
   sequence s_rup_end;
      ##RUP_D !fn_done[0] ##1 fn_done[0];
   endsequence
   chk_ready_always: assert property (fn_ready)
      else $error("function request refused");
   chk_new_clears_done: assert property (
      fn_valid && fn_code != pfs_pkg::FN_DISABLE && fn_code <= pfs_pkg::FN_LAST
      && fn_code != pfs_pkg::FN_RAMP_UP |=> !fn_done[$past(fn_port)])
      else $error("done not cleared by new function");
   chk_disable_done: assert property (
      fn_valid && fn_code == pfs_pkg::FN_DISABLE |=> fn_done[$past(fn_port)])
      else $error("disable did not complete at once");
   chk_sample_time: assert property (
      go0 && fn_code inside {4'h3, 4'h4, 4'h7, [4'h9:4'hc]} |=> s_samp_end)
      else $error("sample done at wrong cycle");
   chk_detect_time: assert property (
      go0 && fn_code inside {4'h1, 4'h2, 4'h5} |=> s_det_end)
      else $error("detect or classify done at wrong cycle");
   chk_ramp_time: assert property (
      go0 && fn_code == pfs_pkg::FN_RAMP_UP |=> s_rup_end)
      else $error("ramp-up done at wrong cycle");
   chk_done_hold: assert property ($fell(fn_done[0]) |-> $past(go0))
      else $error("done dropped without new function");
   chk_read_answer: assert property (1'b1 |=> rd_valid == $past(rd_req))
      else $error("read answer not one cycle after request");
   chk_read_hold: assert property (!$past(rd_req) |-> $stable(rd_data))
      else $error("read data changed without read");
   // codes past the last function must leave the port untouched
   chk_bad_code: assert property (
      go0 && fn_code > pfs_pkg::FN_LAST |=> fn_done[0] == $past(fn_done[0]))
      else $error("unknown function code changed done");
endmodule
`default_nettype wire

// ==== tb/tb_poe_port_function_sequencer.sv ====
`default_nettype none
module tb_poe_port_function_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CONV_C = 16;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_port = 2'h0;
   logic [3:0] cmd_code = 4'h0;
   logic rd_req = 1'b0;
   logic [1:0] rd_port = 2'h0;
   logic [1:0] rd_sel = 2'h0;
   logic [3:0][14:0] adc = 60'h0;
   logic [3:0] uc = 4'h0;
   logic cont = 1'b0;
   logic cmd_ready, rd_ok, rd_stale;
   logic [15:0] rd_data;
   logic [3:0] busy, pl, ph, cl, lg, lf, hf, sw, ru, rdn, ab, flt;
   logic [3:0][1:0] aph, asrc;
   logic [1:0] ph_prev = 2'h0;
   logic bz_prev = 1'b0;
   int k = 0;
   int error_cnt = 0;
   int n_checks = 0;
   logic [3:0] tab [9] = '{pfs_pkg::FN_DISC_LOW, pfs_pkg::FN_DISC_HIGH, pfs_pkg::FN_V_SAMPLE,
      pfs_pkg::FN_LEGACY, pfs_pkg::FN_CLASSIFY, pfs_pkg::FN_LOW_SIDE_AC_PROBE,
      pfs_pkg::FN_HIGH_SIDE_AC_PROBE, pfs_pkg::FN_SINGLE_CURRENT_SAMPLE,
      pfs_pkg::FN_DIE_TEMPERATURE_SAMPLE};
   logic [3:0] ftab [7] = '{pfs_pkg::FN_V_SAMPLE, pfs_pkg::FN_RAMP_UP, pfs_pkg::FN_C_SAMPLE,
      pfs_pkg::FN_RAMP_UP, pfs_pkg::FN_DISABLE, pfs_pkg::FN_RAMP_UP, pfs_pkg::FN_DISABLE};
   logic [1:0] fexp [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
   logic [6:0] fuc = 7'h07;

   pfs_link_if pfs_link_if_i();
   pfs_device_end #(
      .P_SETTLE_CYC(20), .P_CONV_CYC(CONV_C), .P_RAMP_UP_CYC(10), .P_RAMP_DOWN_CYC(8)
   ) pfs_device_end_i (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .link(pfs_link_if_i), .i_adc_value(adc),
      .i_under_current(uc), .o_probe_low(pl), .o_probe_high(ph), .o_class_level(cl),
      .o_legacy_source(lg), .o_low_side_fet(lf), .o_high_side_fet(hf), .o_switch_on(sw),
      .o_ramp_up(ru), .o_ramp_down(rdn), .o_adc_busy(ab), .o_adc_phase(aph),
      .o_adc_source(asrc), .o_fault(flt)
   );
   pfs_host_end pfs_host_end_i (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .link(pfs_link_if_i), .i_cmd_valid(cmd_valid),
      .i_cmd_port(cmd_port), .i_cmd_code(cmd_code), .o_cmd_ready(cmd_ready),
      .i_rd_req(rd_req), .i_rd_port(rd_port), .i_rd_sel(rd_sel), .o_rd_valid(rd_ok),
      .o_rd_stale(rd_stale), .o_rd_data(rd_data), .o_port_busy(busy)
   );
   pfs_link_asserts #(
      .P_SETTLE_CYC(20), .P_CONV_CYC(CONV_C), .P_RAMP_UP_CYC(10)
   ) pfs_link_asserts_i (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .fn_valid(pfs_link_if_i.fn_valid),
      .fn_ready(pfs_link_if_i.fn_ready), .fn_port(pfs_link_if_i.fn_port),
      .fn_code(pfs_link_if_i.fn_code), .fn_done(pfs_link_if_i.fn_done),
      .rd_req(pfs_link_if_i.rd_req), .rd_valid(pfs_link_if_i.rd_valid),
      .rd_data(pfs_link_if_i.rd_data)
   );

   initial begin
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic end_sim();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic tmo();
      error_cnt++;
      end_sim();
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // request stands until the edge that sees ready high
   task automatic cmd(input logic [1:0] p, input logic [3:0] c);
      int n;
      cmd_port <= p;
      cmd_code <= c;
      cmd_valid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge i_clk);
         if (cmd_ready === 1'b1) break;
      end
      cmd_valid <= 1'b0;
      if (n == 100) tmo();
   endtask

   task automatic wait_done(input logic [1:0] p);
      int n;
      for (n = 0; n < 2000; n++) begin
         @(posedge i_clk);
         if (busy[p] === 1'b0) break;
      end
      if (n == 2000) tmo();
   endtask

   task automatic rd(input logic [1:0] p, input logic [1:0] s, input logic [15:0] e);
      int n;
      rd_port <= p;
      rd_sel <= s;
      rd_req <= 1'b1;
      @(posedge i_clk);
      rd_req <= 1'b0;
      for (n = 0; n < 8; n++) begin
         @(posedge i_clk);
         if ((rd_ok | rd_stale) === 1'b1) break;
      end
      if (n == 8) tmo();
      check(rd_data, e);
      check({15'h0, rd_ok}, {15'h0, e[15]});
   endtask

   function automatic logic [1:0] sel_of(input logic [3:0] c);
      case (c)
         pfs_pkg::FN_DISC_LOW, pfs_pkg::FN_DISC_HIGH: return pfs_pkg::RES_DET;
         pfs_pkg::FN_CLASSIFY, pfs_pkg::FN_SINGLE_CURRENT_SAMPLE: return pfs_pkg::RES_CUR;
         pfs_pkg::FN_DIE_TEMPERATURE_SAMPLE: return pfs_pkg::RES_TEMP;
         default: return pfs_pkg::RES_VOLT;
      endcase
   endfunction

   // one-hot of {probe low, probe high, class, low fet, high fet}
   function automatic logic [4:0] lv(input logic [3:0] c);
      case (c)
         pfs_pkg::FN_DISC_LOW: return 5'h10;
         pfs_pkg::FN_DISC_HIGH: return 5'h08;
         pfs_pkg::FN_CLASSIFY: return 5'h04;
         pfs_pkg::FN_LOW_SIDE_AC_PROBE: return 5'h02;
         pfs_pkg::FN_HIGH_SIDE_AC_PROBE: return 5'h01;
         default: return 5'h00;
      endcase
   endfunction

   // port 0 converter phases and continuous slot targets
   always @(posedge i_clk) begin
      if (bz_prev && ab[0] && aph[0] != ph_prev) begin
         check({14'h0, aph[0]}, {14'h0, ph_prev + 2'h1});
      end
      if (cont && ab[0] && aph[0] == 2'h0 && (!bz_prev || ph_prev == 2'h3)) begin
         check({14'h0, asrc[0]},
            {14'h0, (k % 32 == 31) ? pfs_pkg::RES_VOLT : pfs_pkg::RES_CUR});
         k <= k + 1;
      end
      if (!cont) k <= 0;
      bz_prev <= ab[0];
      ph_prev <= aph[0];
   end

   initial begin
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      for (int s = 0; s < 4; s++) begin
         rd(2'h0, 2'(s), 16'h0000);
      end
      for (int i = 0; i < 9; i++) begin
         adc[0] <= 15'h1100 + 15'(i);
         cmd(2'h0, tab[i]);
         @(posedge i_clk);
         cmd_valid <= 1'b1;
         @(posedge i_clk);
         check({15'h0, cmd_ready}, 16'h0000);
         check({15'h0, lg[0]}, {15'h0, tab[i] == pfs_pkg::FN_LEGACY});
         cmd_valid <= 1'b0;
         wait_done(2'h0);
         check({11'h0, pl[0], ph[0], cl[0], lf[0], hf[0]}, {11'h0, lv(tab[i])});
         if (tab[i] == pfs_pkg::FN_CLASSIFY) begin
            cmd_port <= 2'h1;
            cmd_valid <= 1'b1;
            @(posedge i_clk);
            check({15'h0, cmd_ready}, 16'h0000);
            cmd_valid <= 1'b0;
         end
         rd(2'h0, sel_of(tab[i]), {1'b1, 15'h1100 + 15'(i)});
      end
      rd(2'h0, pfs_pkg::RES_DET, 16'h9101);
      cmd(2'h0, pfs_pkg::FN_RAMP_UP);
      @(posedge i_clk);
      check({14'h0, sw[0], ru[0]}, 16'h0003);
      wait_done(2'h0);
      check({14'h0, sw[0], ru[0]}, 16'h0002);
      adc[0] <= 15'h2222;
      cont <= 1'b1;
      cmd(2'h0, pfs_pkg::FN_C_SAMPLE);
      wait_done(2'h0);
      // voltage slot only refreshes once per 32 conversions
      repeat (34 * CONV_C) @(posedge i_clk);
      rd(2'h0, pfs_pkg::RES_VOLT, 16'ha222);
      check({15'h0, flt[0]}, 16'h0000);
      cont <= 1'b0;
      cmd(2'h0, pfs_pkg::FN_RAMP_DOWN);
      @(posedge i_clk);
      check({14'h0, sw[0], rdn[0]}, 16'h0003);
      wait_done(2'h0);
      check({14'h0, sw[0], rdn[0]}, 16'h0000);
      cmd(2'h0, 4'hf);
      @(posedge i_clk);
      check({15'h0, pfs_link_if_i.fn_done[0]}, 16'h0001);
      check({11'h0, pl[0], ph[0], cl[0], lf[0], hf[0]}, 16'h0000);
      for (int i = 0; i < 7; i++) begin
         uc[3] <= fuc[i];
         cmd(2'h3, ftab[i]);
         wait_done(2'h3);
         check({14'h0, flt[3], sw[3]}, {14'h0, fexp[i]});
      end
      end_sim();
   end
endmodule
`default_nettype wire
